// ==== core/swp_ctrl.sv ====
`timescale 1ns/1ns
module swp_ctrl #(
	parameter int STATUS_WRITE_CYCLES = swp_pkg::STATUS_WRITE_CYCLES
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_srst,
	input  wire logic        i_ce,
	input  wire logic        i_sck,
	input  wire logic        i_cs_n,
	input  wire logic        i_serial_in_line,
	input  wire logic        i_wp_n,
	input  wire logic        i_array_busy,
	input  wire logic        i_array_done,
	output logic             o_serial_out,
	output logic             o_serial_out_oe,
	output logic [7:0]       o_status,
	output logic             o_hardware_locked_mode,
	output logic             o_software_locked_mode,
	output logic             o_array_start,
	output logic [7:0]       o_array_opcode,
	output logic [23:0]      o_array_addr,
	output logic             o_protect_reject,
	output logic             o_status_write_reject
);
	// ---------------- link domain (serial clock) ----------------
	logic        armed_q;
	logic [5:0]  bit_cnt_q;
	logic [2:0]  phase_q;
	logic [22:0] shift_q;
	logic [7:0]  opcode_q;
	logic [7:0]  data_byte_q;
	logic [23:0] addr_q;
	logic [7:0]  status_link;
	logic [7:0]  out_shift_q;
	logic        out_bit_q;
	logic        out_oe_q;
	logic        rdsr_active;

	// armed while deselected so that the first edge of a frame restarts the count
	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			armed_q <= 1'b1;
		end else begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sck) begin
		if (!i_cs_n) begin
			if (armed_q) begin
				bit_cnt_q <= 6'h01;
				phase_q   <= 3'h1;
			end else begin
				if (bit_cnt_q != swp_pkg::BITS_MAX) begin
					bit_cnt_q <= bit_cnt_q + 6'h01;
				end
				phase_q <= phase_q + 3'h1;
			end
			shift_q <= {shift_q[21:0], i_serial_in_line};
		end
	end

	// opcode, first following byte and address captured as their last bit arrives [RULE3]
	always_ff @(posedge i_sck) begin
		if (!i_cs_n) begin
			if (armed_q) begin
				opcode_q <= 8'h00;
			end else if (bit_cnt_q == swp_pkg::BITS_OPCODE - 6'h01) begin
				opcode_q <= {shift_q[6:0], i_serial_in_line};
			end
			if (!armed_q && bit_cnt_q == swp_pkg::BITS_STATUS_W - 6'h01) begin
				data_byte_q <= {shift_q[6:0], i_serial_in_line};
			end
			if (!armed_q && bit_cnt_q == swp_pkg::BITS_ADDRESS - 6'h01) begin
				addr_q <= {shift_q[22:0], i_serial_in_line};
			end
		end
	end

	swp_sync #(
		.WIDTH (8)
	) u_status_to_link (
		.i_clk   (i_sck),
		.i_en    (1'b1),
		.i_async (o_status),
		.o_sync  (status_link)
	);

	assign rdsr_active = !armed_q && (opcode_q == swp_pkg::OP_STATUS_READ)
		&& (bit_cnt_q >= swp_pkg::BITS_OPCODE);

	// status byte shifted out on the falling edge, repeating while selected [RULE18] [RULE7]
	always_ff @(negedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			out_oe_q    <= 1'b0;
			out_bit_q   <= 1'b0;
			out_shift_q <= 8'h00;
		end else if (rdsr_active) begin
			out_oe_q <= 1'b1;
			if (phase_q == 3'h0) begin
				out_bit_q   <= status_link[7];
				out_shift_q <= {status_link[6:0], 1'b0};
			end else begin
				out_bit_q   <= out_shift_q[7];
				out_shift_q <= {out_shift_q[6:0], 1'b0};
			end
		end else begin
			out_oe_q <= 1'b0;
		end
	end

	assign o_serial_out    = out_bit_q;
	assign o_serial_out_oe = out_oe_q;

	// ---------------- core domain ----------------
	logic       cs_sync;
	logic       wp_n_sync;
	logic       cs_prev_q;
	logic       frame_end;
	logic       status_write_disable_q;
	logic       tb_q;
	logic [3:0] bp_q;
	logic       wel_q;
	logic [7:0] pending_q;
	logic [$clog2(STATUS_WRITE_CYCLES+1)-1:0] wait_q;
	swp_pkg::swp_state_t state_q;
	logic       hw_locked;
	logic       busy;
	logic       is_program;
	logic       is_erase;
	logic       frame_ok;
	logic       area_hit;
	logic       any_protect;
	logic       start_status_write;
	logic       cycle_done;

	swp_sync #(
		.WIDTH (2)
	) u_pins_to_core (
		.i_clk   (i_core_clk),
		.i_en    (i_ce),
		.i_async ({i_cs_n, i_wp_n}),
		.o_sync  ({cs_sync, wp_n_sync})
	);

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			cs_prev_q <= 1'b1;
		end else if (i_ce) begin
			cs_prev_q <= cs_sync;
		end
	end

	// link registers are quiet once chip select is high, so they are read here directly
	assign frame_end = cs_sync && !cs_prev_q;

	assign hw_locked = status_write_disable_q && !wp_n_sync; // [RULE14] [RULE15]
	assign busy      = (state_q == swp_pkg::SWP_WRITING) || i_array_busy;

	assign is_program = (opcode_q == swp_pkg::OP_PAGE_PROGRAM)
		|| (opcode_q == swp_pkg::OP_DUAL_PROGRAM)
		|| (opcode_q == swp_pkg::OP_DUAL_EXT_PROG)
		|| (opcode_q == swp_pkg::OP_QUAD_PROGRAM)
		|| (opcode_q == swp_pkg::OP_QUAD_EXT_PROG);
	assign is_erase = (opcode_q == swp_pkg::OP_SUBSECTOR_ERASE)
		|| (opcode_q == swp_pkg::OP_SECTOR_ERASE);

	always_comb begin
		frame_ok = 1'b0;
		if (is_program) begin
			frame_ok = (bit_cnt_q >= swp_pkg::BITS_PROG_MIN) && (bit_cnt_q[2:0] == 3'h0);
		end else if (is_erase) begin
			frame_ok = bit_cnt_q == swp_pkg::BITS_ADDRESS;
		end else if (opcode_q == swp_pkg::OP_BULK_ERASE) begin
			frame_ok = bit_cnt_q == swp_pkg::BITS_OPCODE;
		end
	end

	swp_area_lookup #(
		.ADDR_W (24)
	) u_area (
		.i_protect_level     (bp_q),
		.i_top_bottom_select (tb_q),
		.i_addr              (addr_q),
		.o_protected         (area_hit),
		.o_any_protected     (any_protect)
	);

	// exactly one data byte, latch set, not busy, and not hardware locked [RULE1] [RULE5]
	assign start_status_write = frame_end && (state_q == swp_pkg::SWP_IDLE) && !i_array_busy
		&& (opcode_q == swp_pkg::OP_STATUS_WRITE)
		&& (bit_cnt_q == swp_pkg::BITS_STATUS_W)
		&& wel_q && !hw_locked; // [RULE10] [RULE11] [RULE12]

	assign cycle_done = (state_q == swp_pkg::SWP_WRITING) && (wait_q == '0);

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			state_q   <= swp_pkg::SWP_IDLE;
			wait_q    <= '0;
			pending_q <= 8'h00;
		end else if (i_ce) begin
			unique case (state_q)
				swp_pkg::SWP_IDLE: begin
					if (start_status_write) begin // [RULE6]
						state_q   <= swp_pkg::SWP_WRITING;
						wait_q    <= ($clog2(STATUS_WRITE_CYCLES+1))'(STATUS_WRITE_CYCLES - 1);
						pending_q <= data_byte_q;
					end
				end
				swp_pkg::SWP_WRITING: begin
					if (wait_q == '0) begin
						state_q <= swp_pkg::SWP_IDLE;
					end else begin
						wait_q <= wait_q - 1'b1;
					end
				end
			endcase
		end
	end

	// new protect bits take effect when the timed cycle ends; low two bits ignored [RULE4]
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			status_write_disable_q <= swp_pkg::STATUS_WRITE_DISABLE_RESET;
			tb_q   <= swp_pkg::TB_RESET;
			bp_q   <= swp_pkg::BP_RESET;
		end else if (i_ce && cycle_done) begin
			status_write_disable_q <= pending_q[swp_pkg::ST_STATUS_WRITE_DISABLE]; // [RULE9] [RULE16]
			tb_q   <= pending_q[swp_pkg::ST_TB];
			bp_q   <= {pending_q[swp_pkg::ST_BP3], pending_q[swp_pkg::ST_BP0+2:swp_pkg::ST_BP0]};
		end
	end

	// a new write enable wins over a clear in the same cycle
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			wel_q <= 1'b0;
		end else if (i_ce) begin
			if (frame_end && !busy && (opcode_q == swp_pkg::OP_WRITE_ENABLE)
				&& (bit_cnt_q == swp_pkg::BITS_OPCODE)) begin
				wel_q <= 1'b1; // [RULE2]
			end else if (cycle_done || i_array_done) begin
				wel_q <= 1'b0; // [RULE8]
			end
		end
	end

	// program and erase gate against the protected area [RULE17] [RULE13]
	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_array_start    <= 1'b0;
			o_protect_reject <= 1'b0;
			o_array_opcode   <= 8'h00;
			o_array_addr     <= 24'h000000;
		end else if (i_ce) begin
			o_array_start    <= 1'b0;
			o_protect_reject <= 1'b0;
			if (frame_end && frame_ok && wel_q && !busy) begin
				if ((opcode_q == swp_pkg::OP_BULK_ERASE) ? any_protect : area_hit) begin
					o_protect_reject <= 1'b1;
				end else begin
					o_array_start  <= 1'b1;
					o_array_opcode <= opcode_q;
					o_array_addr   <= addr_q;
				end
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_status_write_reject <= 1'b0;
		end else if (i_ce) begin
			o_status_write_reject <= frame_end && (opcode_q == swp_pkg::OP_STATUS_WRITE)
				&& !start_status_write; // [RULE12] [RULE5]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_srst) begin
			o_status               <= 8'h00;
			o_hardware_locked_mode <= 1'b0;
			o_software_locked_mode <= 1'b1;
		end else if (i_ce) begin
			o_status[swp_pkg::ST_WIP]  <= busy; // [RULE7]
			o_status[swp_pkg::ST_WEL]  <= wel_q;
			o_status[swp_pkg::ST_BP0+2:swp_pkg::ST_BP0] <= bp_q[2:0];
			o_status[swp_pkg::ST_TB]   <= tb_q;
			o_status[swp_pkg::ST_BP3]  <= bp_q[3];
			o_status[swp_pkg::ST_STATUS_WRITE_DISABLE] <= status_write_disable_q;
			o_hardware_locked_mode     <= hw_locked;
			o_software_locked_mode     <= !hw_locked;
		end
	end
endmodule

// ==== core/swp_pkg.sv ====
// Behaviour
// RULE1: status write needs write enable latch set
// RULE2: write enable command sets the latch
// RULE3: host frames opcode then one data byte
// RULE4: status bits one and zero never written
// RULE5: deselect only after eighth data bit
// RULE6: correct frame end starts timed status write
// RULE7: status readable; busy bit tracks the cycle
// RULE8: latch cleared when the cycle completes
// RULE9: status write loads protect levels and disable
// RULE10: disable clear: writes allowed with latch set
// RULE11: disable set, pin high: writes still allowed
// RULE12: disable set, pin low: writes rejected
// RULE13: hardware lock also shields protected area
// RULE14: hardware lock whenever disable set, pin low
// RULE15: only pin high leaves hardware lock
// RULE16: software lock lets all protect bits change
// RULE17: refuse program and erase in protected area
// RULE18: status reads accepted even while busy
// RULE19: protect levels mapped by fixed lookup table
package swp_pkg;
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_STATUS_WRITE   = 8'h01;
	localparam logic [7:0] OP_STATUS_READ    = 8'h05;
	localparam logic [7:0] OP_PAGE_PROGRAM   = 8'h02;
	localparam logic [7:0] OP_DUAL_PROGRAM   = 8'hA2;
	localparam logic [7:0] OP_DUAL_EXT_PROG  = 8'hD2;
	localparam logic [7:0] OP_QUAD_PROGRAM   = 8'h32;
	localparam logic [7:0] OP_QUAD_EXT_PROG  = 8'h12;
	localparam logic [7:0] OP_SUBSECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_SECTOR_ERASE   = 8'hD8;
	localparam logic [7:0] OP_BULK_ERASE     = 8'hC7;

	// status byte field positions
	localparam int ST_WIP  = 0;
	localparam int ST_WEL  = 1;
	localparam int ST_BP0  = 2;
	localparam int ST_TB   = 5;
	localparam int ST_BP3  = 6;
	localparam int ST_STATUS_WRITE_DISABLE = 7;

	// frame lengths in serial clock bits
	localparam logic [5:0] BITS_OPCODE   = 6'h08;
	localparam logic [5:0] BITS_STATUS_W = 6'h10;
	localparam logic [5:0] BITS_ADDRESS  = 6'h20;
	localparam logic [5:0] BITS_PROG_MIN = 6'h28;
	localparam logic [5:0] BITS_MAX      = 6'h3F;

	localparam logic       STATUS_WRITE_DISABLE_RESET = 1'b0;
	localparam logic       TB_RESET   = 1'b0;
	localparam logic [3:0] BP_RESET   = 4'h0;

	localparam int CORE_CLK_NS        = 40;
	localparam int STATUS_WRITE_NS    = 8000;
	localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;

	localparam int SECTOR_ADDR_LSB = 16;
	localparam int SECTOR_COUNT    = 256;

	typedef enum logic [0:0] {
		SWP_IDLE,
		SWP_WRITING
	} swp_state_t;
endpackage

// ==== core/swp_sync.sv ====
`timescale 1ns/1ns
module swp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk,
	input  wire logic             i_en,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge i_clk) begin
		if (i_en) begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

// ==== core/swp_area_lookup.sv ====
`timescale 1ns/1ns
module swp_area_lookup #(
	parameter int ADDR_W = 24
) (
	input  wire logic [3:0]        i_protect_level,
	input  wire logic              i_top_bottom_select,
	input  wire logic [ADDR_W-1:0] i_addr,
	output logic                   o_protected,
	output logic                   o_any_protected
);
	// protected sector count per protect level, fixed table [RULE19]
	localparam logic [8:0] SECTORS_PROTECTED [16] = '{
		9'h000, 9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h040,
		9'h080, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100, 9'h100
	};
	localparam logic [8:0] SECTOR_TOTAL = 9'(swp_pkg::SECTOR_COUNT);

	logic [8:0] count;
	logic [8:0] sector;

	always_comb begin
		count  = SECTORS_PROTECTED[i_protect_level];
		sector = {1'b0, i_addr[ADDR_W-1:swp_pkg::SECTOR_ADDR_LSB]};
		if (i_top_bottom_select) begin
			o_protected = sector < count;
		end else begin
			o_protected = sector >= (SECTOR_TOTAL - count);
		end
		o_protected     = o_protected && (count != 9'h000); // [RULE17]
		o_any_protected = count != 9'h000;
	end
endmodule

// ==== bench/swp_ctrl_asserts.sv ====
`timescale 1ns/1ns
module swp_ctrl_asserts #(
	parameter int STATUS_WRITE_CYCLES = 5
) (
	input wire logic       i_core_clk,
	input wire logic       i_srst,
	input wire logic       i_cs_n,
	input wire logic       i_wp_n,
	input wire logic       i_array_busy,
	input wire logic [7:0] o_status,
	input wire logic       o_hardware_locked_mode,
	input wire logic       o_software_locked_mode,
	input wire logic       o_array_start,
	input wire logic [7:0] o_array_opcode,
	input wire logic       o_protect_reject,
	input wire logic       o_status_write_reject
);
	int busy_q;
	always_ff @(posedge i_core_clk)
		busy_q <= (i_srst || !o_status[0]) ? 0 : busy_q + 1;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	property p_lk; o_hardware_locked_mode != o_software_locked_mode; endproperty
	a_lk: assert property (p_lk) else $error("lock modes clash");
	property p_hw_on; (o_status[7] && !i_wp_n) [*5] |-> o_hardware_locked_mode; endproperty
	a_hw_on: assert property (p_hw_on) else $error("lock not entered");
	property p_hw_off; i_wp_n [*5] |-> !o_hardware_locked_mode; endproperty
	a_hw_off: assert property (p_hw_off) else $error("lock not left");
	property p_frz; o_hardware_locked_mode && $past(o_hardware_locked_mode) |-> $stable(o_status[7:2]);
	endproperty
	a_frz: assert property (p_frz) else $error("protect bits changed in lock");
	property p_rej; o_status_write_reject |=> !$rose(o_status[0]); endproperty
	a_rej: assert property (p_rej) else $error("refused write ran");
	property p_len; $fell(o_status[0]) && !$past(i_array_busy) |->
		busy_q >= STATUS_WRITE_CYCLES && busy_q <= STATUS_WRITE_CYCLES + 2; endproperty
	a_len: assert property (p_len) else $error("busy length wrong");
	property p_wel; $fell(o_status[0]) && !$past(i_array_busy) |-> !o_status[1]; endproperty
	a_wel: assert property (p_wel) else $error("latch kept after write");
	property p_go; $rose(o_status[0]) && !i_array_busy |-> $past(i_cs_n, 2); endproperty
	a_go: assert property (p_go) else $error("busy without deselect");
	property p_be; o_array_start && o_array_opcode == swp_pkg::OP_BULK_ERASE |->
		{o_status[6], o_status[4:2]} == 4'h0; endproperty
	a_be: assert property (p_be) else $error("bulk erase while protected");
	c_hw: cover property ($rose(o_hardware_locked_mode));
	c_rej: cover property (o_status_write_reject);
	c_prot: cover property (o_protect_reject);
endmodule

// ==== bench/swp_host.sv ====
`timescale 1ns/1ns
module swp_host (
	input  wire logic i_serial_out,
	input  wire logic i_serial_out_oe,
	output logic o_sck,
	output logic o_cs_n,
	output logic o_serial_in_line
);
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_serial_in_line = 1'b0;
	end
	// msb first, clock still outside frames, deselect after last bit
	task automatic frame(input logic [63:0] b, input int n);
		o_cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			o_serial_in_line = b[i];
			#3 o_sck = 1'b1;
			#3 o_sck = 1'b0;
		end
		#3 o_cs_n = 1'b1;
		o_serial_in_line = ~o_serial_in_line;
	endtask
	// status read opcode, then two bytes sampled on the rising edge
	task automatic read_status(output logic [15:0] v, output logic oe);
		oe = 1'b1;
		o_cs_n = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			o_serial_in_line = swp_pkg::OP_STATUS_READ[i];
			#3 o_sck = 1'b1;
			#3 o_sck = 1'b0;
		end
		o_serial_in_line = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			#3 o_sck = 1'b1;
			v[i] = i_serial_out;
			oe = oe & i_serial_out_oe;
			#3 o_sck = 1'b0;
		end
		#3 o_cs_n = 1'b1;
	endtask
endmodule

// ==== bench/status_write_and_protect_ctrl_tb_top.sv ====
`timescale 1ns/1ns
module status_write_and_protect_ctrl_tb_top;
	logic        clk, srst, wp_n, sck, cs_n, sin, hw, sw, a_st, p_rej, w_rej;
	logic        so, so_oe;
	logic [7:0]  st, a_op, e_st, got_op;
	logic [23:0] a_ad, got_ad;
	logic [23:0] n_w = '0, n_p = '0, n_s = '0, x_w = '0, x_p = '0, x_s = '0;
	int fails = 0;
	int comparisons = 0;
	logic [7:0] ops [7] = '{swp_pkg::OP_PAGE_PROGRAM, swp_pkg::OP_DUAL_PROGRAM,
		swp_pkg::OP_DUAL_EXT_PROG, swp_pkg::OP_QUAD_PROGRAM, swp_pkg::OP_QUAD_EXT_PROG,
		swp_pkg::OP_SUBSECTOR_ERASE, swp_pkg::OP_SECTOR_ERASE};
	swp_ctrl #(.STATUS_WRITE_CYCLES(5)) uut (
		.i_core_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_sck(sck), .i_cs_n(cs_n),
		.i_serial_in_line(sin), .i_wp_n(wp_n), .i_array_busy(1'b0), .i_array_done(1'b0),
		.o_serial_out(so), .o_serial_out_oe(so_oe), .o_status(st), .o_hardware_locked_mode(hw),
		.o_software_locked_mode(sw), .o_array_start(a_st), .o_array_opcode(a_op),
		.o_array_addr(a_ad), .o_protect_reject(p_rej), .o_status_write_reject(w_rej));
	swp_host host (.i_serial_out(so), .i_serial_out_oe(so_oe), .o_sck(sck), .o_cs_n(cs_n),
		.o_serial_in_line(sin));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		if (w_rej === 1'b1) n_w++;
		if (p_rej === 1'b1) n_p++;
		if (a_st === 1'b1) begin
			n_s++;
			got_op = a_op;
			got_ad = a_ad;
		end
	end
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		comparisons++;
		if (e !== g) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic send(input logic [63:0] b, input int n);
		host.frame(b, n);
		cyc(8);
	endtask
	task automatic write_enable_command();
		send(64'h06, 8);
		e_st[1] = 1'b1;
		chk("status", 24'(e_st), 24'(st));
	endtask
	task automatic wait_b0(input logic v);
		int k;
		k = 0;
		while (st[0] !== v && k < 40) begin
			cyc(1);
			k++;
		end
	endtask
	task automatic status_write_command(input logic [7:0] d, input bit ok);
		host.frame({48'h0, 8'h01, d}, 16);
		if (ok) begin
			wait_b0(1'b1);
			chk("busy", 24'h1, 24'(st[0]));
			wait_b0(1'b0);
			cyc(1);
			e_st = {d[7:2], 2'b00};
		end else begin
			cyc(8);
			x_w++;
		end
		chk("status", 24'(e_st), 24'(st));
		chk("wr_rej", x_w, n_w);
	endtask
	task automatic rdsr();
		logic [15:0] v;
		logic        oe;
		host.read_status(v, oe);
		cyc(8);
		chk("status_read", 24'({e_st, e_st}), 24'(v));
		chk("read_oe", 24'h1, 24'(oe));
	endtask
	task automatic opf(input int i, input logic [23:0] ad);
		send(64'({ops[i], ad, 8'hA5}) >> (i < 5 ? 0 : 8), i < 5 ? 40 : 32);
	endtask
	initial begin
		logic [23:0] ad;
		srst = 1'b1;
		wp_n = 1'b1;
		e_st = 8'h00;
		void'($urandom(32'h74F133A9));
		cyc(4);
		srst = 1'b0;
		cyc(4);
		chk("locks", 24'h1, 24'({hw, sw}));
		status_write_command(8'h3C, 1'b0);
		write_enable_command();
		send(64'h009E, 15);
		send(64'h00278, 17);
		x_w += 2;
		chk("wr_rej", x_w, n_w);
		status_write_command({1'b0, 7'($urandom)}, 1'b1);
		write_enable_command();
		status_write_command(8'h04, 1'b1);
		rdsr();
		for (int i = 0; i < 7; i++) begin
			write_enable_command();
			opf(i, {8'hFF, 16'($urandom)});
			x_p++;
			chk("prot_rej", x_p, n_p);
			ad = {1'b0, 23'($urandom)};
			opf(i, ad);
			x_s++;
			chk("starts", x_s, n_s);
			chk("opcode", 24'(ops[i]), 24'(got_op));
			chk("addr", ad, got_ad);
		end
		write_enable_command();
		send(64'hC7, 8);
		x_p++;
		chk("prot_rej", x_p, n_p);
		status_write_command(8'h00, 1'b1);
		write_enable_command();
		send(64'hC7, 8);
		x_s++;
		chk("starts", x_s, n_s);
		wp_n = 1'b0;
		write_enable_command();
		status_write_command(8'h84, 1'b1);
		cyc(6);
		chk("locks", 24'h2, 24'({hw, sw}));
		write_enable_command();
		status_write_command(8'h00, 1'b0);
		rdsr();
		opf(0, 24'hFF0000);
		x_p++;
		chk("prot_rej", x_p, n_p);
		wp_n = 1'b1;
		cyc(6);
		chk("locks", 24'h1, 24'({hw, sw}));
		status_write_command(8'h7C, 1'b1);
		print_verdict();
	end
	initial begin
		#400000;
		fails++;
		print_verdict();
	end
endmodule
bind swp_ctrl swp_ctrl_asserts #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) u_chk (
	.i_core_clk(i_core_clk), .i_srst(i_srst), .i_cs_n(i_cs_n), .i_wp_n(i_wp_n),
	.i_array_busy(i_array_busy), .o_status(o_status),
	.o_hardware_locked_mode(o_hardware_locked_mode),
	.o_software_locked_mode(o_software_locked_mode), .o_array_start(o_array_start),
	.o_array_opcode(o_array_opcode), .o_protect_reject(o_protect_reject),
	.o_status_write_reject(o_status_write_reject));
